// [hdl/ivm_top.v]
// ivm_top.v - interrupt vector mapper: pending flags, enables, global
// enable, priority pick and program word address for the core.
// assumes peripherals pulse src_event/src_clear in the sys_clk domain and
// that software reaches the registers over Avalon-MM with waitrequest.
`timescale 1ns/1ps
`include "ivm_map.vh"
module ivm_top
#(
  parameter LARGE_FLASH = 1,
  parameter PIN_COUNT = 24
)
(
  sys_clk,
  sys_rst,
  ce,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_readdata,
  avs_waitrequest,
  src_event,
  src_clear,
  core_req,
  core_nmi,
  core_vector,
  core_word_addr,
  irq
);
  input wire sys_clk;
  input wire sys_rst;
  input wire ce;
  input wire [4:0] avs_address;
  input wire avs_read;
  input wire avs_write;
  input wire [31:0] avs_writedata;
  output reg [31:0] avs_readdata;
  output wire avs_waitrequest;
  input wire [30:0] src_event;
  input wire [30:0] src_clear;
  output reg core_req;
  output reg core_nmi;
  output reg [4:0] core_vector;
  output wire [7:0] core_word_addr;
  output wire irq;

  reg [30:0] flag_q;
  reg [30:0] flag_d;
  reg [30:0] enable_q;
  reg [31:0] ctrl_q;
  reg [1:0] evstat_q;
  reg [1:0] evstat_d;
  reg [1:0] evmask_q;
  reg ack_q;
  reg [30:0] impl_mask;
  reg [30:0] req_vec;
  reg [4:0] pick_num;
  reg pick_valid;
  reg [31:0] rd_mux;
  reg req_prev_q;
  reg [4:0] vec_prev_q;
  integer i;

  wire bus_req;
  wire acc_now;
  wire wr_now;
  wire gie;
  wire split_mode;

  // vector number of each source; a number missing here has no source
  // scan nmi and voltage warning
  localparam [4:0] V_MEMORY_SCAN_NONMASKABLE = 5'h01;
  localparam [4:0] V_VOLTAGE_LEVEL_WARNING = 5'h02;
  // pin change of ports a, b, c
  localparam [4:0] V_PIN_CHANGE_A = 5'h03;
  localparam [4:0] V_PIN_CHANGE_B = 5'h04;
  localparam [4:0] V_PIN_CHANGE_C = 5'h05;
  localparam [4:0] V_COUNTER_COUNT = 5'h06;
  localparam [4:0] V_PERIODIC_TICK = 5'h07;
  // timer a, low byte sources in split mode
  localparam [4:0] V_TIMER_A_OVERFLOW = 5'h08;
  localparam [4:0] V_TIMER_A_HIGH_UNDERFLOW = 5'h09;
  localparam [4:0] V_TIMER_A_COMPARE0 = 5'h0a;
  localparam [4:0] V_TIMER_A_COMPARE1 = 5'h0b;
  localparam [4:0] V_TIMER_A_COMPARE2 = 5'h0c;
  localparam [4:0] V_TIMER_B_CAPTURE = 5'h0d;
  localparam [4:0] V_COMPARATOR = 5'h11;
  localparam [4:0] V_CONVERTER_RESULT_READY = 5'h14;
  localparam [4:0] V_CONVERTER_WINDOW_COMPARE = 5'h15;
  localparam [4:0] V_TWO_WIRE_CLIENT = 5'h18;
  localparam [4:0] V_TWO_WIRE_HOST = 5'h19;
  localparam [4:0] V_SPI_TRANSFER = 5'h1a;
  localparam [4:0] V_SERIAL_RX_COMPLETE = 5'h1b;
  localparam [4:0] V_SERIAL_TX_BUFFER_EMPTY = 5'h1c;
  localparam [4:0] V_SERIAL_TX_COMPLETE = 5'h1d;
  // eeprom ready is the last vector
  localparam [4:0] V_EEPROM_READY = 5'h1e;

  // lowest set bit index of a request vector
  function [5:0] lowest_set;
    input [30:0] bits;
    integer k;
    begin
      lowest_set = 6'h00;
      for (k = `IVM_NVEC - 1; k >= 0; k = k - 1)
        if (bits[k])
          lowest_set = {1'b1, k[4:0]};
    end
  endfunction

  // register select used by the write paths; the read mux decodes the offset with a case
  function is_reg;
    input [4:0] addr;
    input [4:0] ofs;
    begin
      is_reg = (addr == ofs);
    end
  endfunction

  assign gie = ctrl_q[`IVM_CTRL_GIE];
  assign split_mode = ctrl_q[`IVM_CTRL_SPLIT];

  // bus handshake: one wait cycle, answer on the second
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_q;
  assign acc_now = bus_req & ack_q;
  assign wr_now = avs_write & ack_q;

  always @(posedge sys_clk)
  begin
    if (sys_rst)
      ack_q <= 1'b0;
    else if (ce)
      ack_q <= bus_req & ~ack_q;
  end

  // which vectors exist on this part and in this timer mode
  always @*
  begin
    impl_mask = 31'h0000_0000;
    impl_mask[V_MEMORY_SCAN_NONMASKABLE] = 1'b1;
    impl_mask[V_VOLTAGE_LEVEL_WARNING] = 1'b1;
    impl_mask[V_PIN_CHANGE_A] = 1'b1;
    impl_mask[V_PIN_CHANGE_B] = 1'b1;
    impl_mask[V_PIN_CHANGE_C] = 1'b1;
    impl_mask[V_COUNTER_COUNT] = 1'b1;
    impl_mask[V_PERIODIC_TICK] = 1'b1;
    impl_mask[V_TIMER_B_CAPTURE] = 1'b1;
    impl_mask[V_TIMER_A_OVERFLOW] = 1'b1;
    impl_mask[V_TIMER_A_HIGH_UNDERFLOW] = 1'b1;
    impl_mask[V_TIMER_A_COMPARE0] = 1'b1;
    impl_mask[V_TIMER_A_COMPARE1] = 1'b1;
    impl_mask[V_TIMER_A_COMPARE2] = 1'b1;
    impl_mask[V_COMPARATOR] = 1'b1;
    impl_mask[V_CONVERTER_RESULT_READY] = 1'b1;
    impl_mask[V_CONVERTER_WINDOW_COMPARE] = 1'b1;
    impl_mask[V_TWO_WIRE_CLIENT] = 1'b1;
    impl_mask[V_TWO_WIRE_HOST] = 1'b1;
    impl_mask[V_SPI_TRANSFER] = 1'b1;
    impl_mask[V_SERIAL_RX_COMPLETE] = 1'b1;
    impl_mask[V_SERIAL_TX_BUFFER_EMPTY] = 1'b1;
    impl_mask[V_SERIAL_TX_COMPLETE] = 1'b1;
    // eeprom ready; header mask must agree with the list
    impl_mask[V_EEPROM_READY] = 1'b1;
    impl_mask = impl_mask & `IVM_IMPL_MASK;
    // vector 0 is the reset entry only
    impl_mask[`IVM_VEC_RESET] = 1'b0;
    // port C only on larger packages
    if (PIN_COUNT < 20)
      impl_mask[`IVM_VEC_PORTC] = 1'b0;
    // high underflow only in split mode
    if (!split_mode)
      impl_mask[`IVM_VEC_HIGH_UNF] = 1'b0;
  end

  // pending flags: hardware set beats any clear in the same cycle
  always @*
  begin
    flag_d = flag_q;
    // cleared by software or peripheral clear, and vector 9 also when split mode is left
    flag_d = flag_d & ~src_clear;
    if (wr_now && is_reg(avs_address, `IVM_OFS_FLAG))
      flag_d = flag_d & ~avs_writedata[30:0];
    flag_d = flag_d | (src_event & impl_mask);
    // absent vectors never hold a flag
    flag_d = flag_d & impl_mask;
  end

  always @(posedge sys_clk)
  begin
    if (sys_rst)
      flag_q <= 31'h0000_0000;
    else if (ce)
      flag_q <= flag_d;
  end

  // enable bits and control written by software
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      enable_q <= 31'h0000_0000;
      ctrl_q <= `IVM_CTRL_RST;
      evmask_q <= 2'h0;
    end
    else if (ce && wr_now)
    begin
      if (is_reg(avs_address, `IVM_OFS_ENABLE))
        enable_q <= avs_writedata[30:0];
      if (is_reg(avs_address, `IVM_OFS_CTRL))
        ctrl_q <= {30'h0, avs_writedata[`IVM_CTRL_SPLIT], avs_writedata[`IVM_CTRL_GIE]};
      if (is_reg(avs_address, `IVM_OFS_EVMASK))
        evmask_q <= avs_writedata[1:0];
    end
  end

  // request formation and priority pick
  always @*
  begin
    req_vec = flag_q & enable_q & impl_mask;
    for (i = 0; i < `IVM_NVEC; i = i + 1)
      if (!gie && i != `IVM_VEC_NMI)
        req_vec[i] = 1'b0;
    req_vec[`IVM_VEC_NMI] = flag_q[`IVM_VEC_NMI];
    {pick_valid, pick_num} = lowest_set(req_vec);
  end

  // one vector per source, fixed by bit position
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      core_req <= 1'b0;
      core_nmi <= 1'b0;
      core_vector <= 5'h00;
    end
    else if (ce)
    begin
      core_req <= pick_valid;
      core_nmi <= pick_valid && (pick_num == `IVM_VEC_NMI);
      core_vector <= pick_valid ? pick_num : 5'h00;
    end
  end

  // address lookup follows the picked vector by one cycle
  ivm_addr_rom u_addr_rom
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .large_flash(LARGE_FLASH != 0),
    .vec_num(core_vector),
    .word_addr_q(core_word_addr)
  );

  // event edges seen by software: a new request vector, or a scan nmi
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      req_prev_q <= 1'b0;
      vec_prev_q <= 5'h00;
    end
    else if (ce)
    begin
      req_prev_q <= core_req;
      vec_prev_q <= core_vector;
    end
  end

  // sticky event bits, write one to clear, set wins
  always @*
  begin
    evstat_d = evstat_q;
    if (wr_now && is_reg(avs_address, `IVM_OFS_EVSTAT))
      evstat_d = evstat_d & ~avs_writedata[1:0];
    if (core_req && (!req_prev_q || core_vector != vec_prev_q))
      evstat_d[`IVM_EV_NEW] = 1'b1;
    if (core_nmi)
      evstat_d[`IVM_EV_NMI] = 1'b1;
  end

  always @(posedge sys_clk)
  begin
    if (sys_rst)
      evstat_q <= 2'h0;
    else if (ce)
      evstat_q <= evstat_d;
  end

  // level interrupt; the core request path stays separate from this one
  assign irq = |(evstat_q & evmask_q);

  // read mux; unmapped offsets read as zero
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `IVM_OFS_FLAG: rd_mux = {1'b0, flag_q};
      `IVM_OFS_ENABLE: rd_mux = {1'b0, enable_q};
      `IVM_OFS_CTRL: rd_mux = ctrl_q;
      `IVM_OFS_VECTOR:
      begin
        rd_mux[`IVM_VEC_VALID] = core_req;
        rd_mux[`IVM_VEC_NUM_LSB +: 5] = core_vector;
        rd_mux[`IVM_VEC_ADDR_LSB +: 8] = core_word_addr;
      end
      `IVM_OFS_EVSTAT: rd_mux = {30'h0, evstat_q};
      `IVM_OFS_EVMASK: rd_mux = {30'h0, evmask_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, stands while waitrequest is low
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      avs_readdata <= 32'h0000_0000;
    else if (ce && avs_read && !ack_q)
      avs_readdata <= rd_mux;
  end
endmodule

// [hdl/ivm_map.vh]
// ivm_map.vh - register offsets, field positions, reset values and
// vector numbers of the interrupt vector mapper.
// assumes byte addressing on a 32-bit Avalon-MM slave, one word per register.
//
// Notes on behaviour
// - each vector belongs to one peripheral
// - source event sets its pending flag
// - enable bit written per source
// - request only when flag and enable set, scan nmi on its flag alone
// - request holds until flag, enable or global enable is cleared
// - global enable gates every maskable request
// - large flash: word address is twice vector
// - small flash: address equals vector up to 13, 17 at 16, later gaps removed
// - vector 0 reset, 1 scan nmi, 2 voltage
// - vectors 3-5 pin change, C needs 20 pins
// - vectors 6,7 counter; 13 timer b capture
// - vectors 8,10-12 timer a normal or split
// - vector 9 only used in split mode
// - 17 comparator; 20,21 converter result, window
// - 24-26 two-wire, spi; 27-29 serial port
// - 30 eeprom ready; unlisted vectors absent
`ifndef IVM_MAP_VH
`define IVM_MAP_VH

// register byte offsets
`define IVM_OFS_FLAG 5'h00
`define IVM_OFS_ENABLE 5'h04
`define IVM_OFS_CTRL 5'h08
`define IVM_OFS_VECTOR 5'h0c
`define IVM_OFS_EVSTAT 5'h10
`define IVM_OFS_EVMASK 5'h14

// control register fields
`define IVM_CTRL_GIE 0
`define IVM_CTRL_SPLIT 1
`define IVM_CTRL_RST 32'h0000_0000

// vector register fields
`define IVM_VEC_VALID 31
`define IVM_VEC_NUM_LSB 8
`define IVM_VEC_ADDR_LSB 0

// event status bits
`define IVM_EV_NEW 0
`define IVM_EV_NMI 1

// vector numbers with a special role
`define IVM_VEC_RESET 5'h00
`define IVM_VEC_NMI 5'h01
`define IVM_VEC_PORTC 5'h05
`define IVM_VEC_HIGH_UNF 5'h09

// vectors with a listed source: 1-13, 17, 20, 21, 24-30
`define IVM_IMPL_MASK 31'h7f32_3ffe
`define IVM_NVEC 31
`endif

// [hdl/ivm_addr_rom.v]
// ivm_addr_rom.v - maps a vector number to its program word address.
// assumes the vector number is held stable by the caller; output registered.
`timescale 1ns/1ps
module ivm_addr_rom
(
  sys_clk,
  sys_rst,
  ce,
  large_flash,
  vec_num,
  word_addr_q
);
  input wire sys_clk;
  input wire sys_rst;
  input wire ce;
  input wire large_flash;
  input wire [4:0] vec_num;
  output reg [7:0] word_addr_q;

  // compact layout for the small parts, 17 moved down to 16, later numbering gaps squeezed out
  function [7:0] small_addr;
    input [4:0] v;
    begin
      case (v)
        5'h11: small_addr = 8'h10;
        5'h14: small_addr = 8'h11;
        5'h15: small_addr = 8'h12;
        5'h18: small_addr = 8'h13;
        5'h19: small_addr = 8'h14;
        5'h1a: small_addr = 8'h15;
        5'h1b: small_addr = 8'h16;
        5'h1c: small_addr = 8'h17;
        5'h1d: small_addr = 8'h18;
        5'h1e: small_addr = 8'h19;
        default: small_addr = {3'h0, v};
      endcase
    end
  endfunction

  // one register stage keeps the address a clean flop output
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      word_addr_q <= 8'h00;
    else if (ce)
    begin
      if (large_flash)
        word_addr_q <= {2'h0, vec_num, 1'b0};
      else
        word_addr_q <= small_addr(vec_num);
    end
  end
endmodule

// [tb/ivm_top_props.sv]
// port checker for the vector mapper
// assumes ce held high; bound to every ivm_top
`timescale 1ns/1ps
module ivm_props
#(
  parameter LARGE_FLASH = 1,
  parameter PIN_COUNT = 24
)
(
  input wire sys_clk,
  input wire sys_rst,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [30:0] src_event,
  input wire [30:0] src_clear,
  input wire core_req,
  input wire core_nmi,
  input wire [4:0] core_vector,
  input wire [7:0] core_word_addr,
  input wire irq
);
  // port c vector absent below 20 pins
  localparam [30:0] impl = 31'h7f32_3ffe & ~(PIN_COUNT < 20 ? 31'h20 : 31'h0);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // address per layout; when small, 17 sits at 16 and later gaps are squeezed out
  function automatic [7:0] wa(input [4:0] n);
    wa = LARGE_FLASH ? {n, 1'b0} : n < 14 ? n : n < 18 ? n - 5'h1 : n < 22 ? n - 5'h3 : n - 5'h5;
  endfunction
  property p_rvec; core_req |-> core_vector != 5'h00; endproperty
  property p_impl; core_req |-> impl[core_vector]; endproperty
  property p_nmi; core_nmi == (core_req && core_vector == 5'h01); endproperty
  property p_big; LARGE_FLASH == 1 && $past(core_vector) == core_vector |-> core_word_addr == wa(core_vector); endproperty
  property p_small; LARGE_FLASH == 0 && $past(core_vector) == core_vector |-> core_word_addr == wa(core_vector); endproperty
  property p_go; src_event[1] ##1 1'b1 |=> core_nmi; endproperty
  // a clear two samples back is the only way out besides reset
  property p_hold; $fell(core_nmi) && !$past(sys_rst) |-> $past(src_clear[1] || (avs_write && !avs_waitrequest), 2);
  endproperty
  property p_wait; (avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_rvec: assert property (p_rvec) else $error("vector 0 requested");
  a_impl: assert property (p_impl) else $error("absent vector requested");
  a_nmi: assert property (p_nmi) else $error("nmi flag wrong");
  a_big: assert property (p_big) else $error("large address wrong");
  a_small: assert property (p_small) else $error("small address wrong");
  a_go: assert property (p_go) else $error("nmi not presented");
  a_hold: assert property (p_hold) else $error("nmi dropped");
  a_wait: assert property (p_wait) else $error("wait cycle wrong");
  c_nmi: cover property (core_nmi);
  c_top: cover property (core_req && core_vector == 5'h1e);
  c_irq: cover property ($rose(irq));
endmodule
bind ivm_top ivm_props #(.LARGE_FLASH(LARGE_FLASH), .PIN_COUNT(PIN_COUNT)) u_ivm_props (.sys_clk, .sys_rst,
  .avs_read, .avs_write, .avs_waitrequest, .src_event, .src_clear, .core_req, .core_nmi, .core_vector,
  .core_word_addr, .irq);

// [tb/ivm_src_model.sv]
// peripheral side: one line per vector
// assumes bench pulses requests one cycle
`timescale 1ns/1ps
module ivm_src_model
(
  input wire sys_clk,
  input wire [30:0] ev_req,
  input wire [30:0] cl_req,
  output reg [30:0] src_event = 31'h0,
  output reg [30:0] src_clear = 31'h0
);
  always @(posedge sys_clk)
  begin
    src_event <= ev_req;
    src_clear <= cl_req;
  end
endmodule

// [tb/tb_ivm_top.sv]
// bench: large and small layout side by side
// assumes ce tied high, shared register bus
`timescale 1ns/1ps
module tb_ivm_top;
  reg sys_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [4:0] adr = 5'h00;
  reg rd_en = 1'b0;
  reg wr_en = 1'b0;
  reg [31:0] wd = 32'h0;
  reg [30:0] ev = 31'h0;
  reg [30:0] cl = 31'h0;
  wire [31:0] rdata;
  wire wait_l, req_l, req_s, nmi, irq;
  wire [4:0] vec;
  wire [7:0] wa_l, wa_s;
  wire [30:0] src_event, src_clear;
  integer seed = 32'h518e9955;
  integer err_total = 0;
  integer compares = 0;
  integer i;
  reg [4:0] v;
  reg [31:0] rd;
  ivm_src_model u_ivm_src_model (.sys_clk(sys_clk), .ev_req(ev), .cl_req(cl), .src_event(src_event),
    .src_clear(src_clear));
  ivm_top u_ivm_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(1'b1), .avs_address(adr), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wait_l), .src_event(src_event),
    .src_clear(src_clear), .core_req(req_l), .core_nmi(nmi), .core_vector(vec), .core_word_addr(wa_l), .irq(irq));
  ivm_top #(.LARGE_FLASH(0), .PIN_COUNT(14)) u_ivm_top_small (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(1'b1),
    .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wd), .avs_readdata(),
    .avs_waitrequest(), .src_event(src_event), .src_clear(src_clear), .core_req(req_s), .core_nmi(),
    .core_vector(), .core_word_addr(wa_s), .irq());
  initial forever #20 sys_clk = ~sys_clk;
  // expected word address, independent of the design
  function [7:0] wa(input [4:0] n, input l);
    wa = l ? {n, 1'b0} : n < 14 ? n : n < 18 ? n - 5'h1 : n < 22 ? n - 5'h3 : n - 5'h5;
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  // holds the request until waitrequest is sampled low
  task bus(input w, input [4:0] a, input [31:0] d);
  begin
    adr <= a;
    wd <= d;
    wr_en <= w;
    rd_en <= !w;
    @(posedge sys_clk);
    while (wait_l !== 1'b0) @(posedge sys_clk);
    rd = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
  end
  endtask
  task pulse(input [30:0] e, input [30:0] c);
  begin
    ev <= e;
    cl <= c;
    @(posedge sys_clk);
    ev <= 31'h0;
    cl <= 31'h0;
    repeat (5) @(posedge sys_clk);
  end
  endtask
  task end_sim;
  begin
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // hang guard, about fifteen times the expected run
  initial
  begin
    #400000;
    err_total = err_total + 1;
    end_sim;
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    bus(0, 5'h08, 0); chk(rd, 0);
    bus(0, 5'h1c, 0); chk(rd, 0);
    // nmi with all enables off, then the interrupt line
    bus(1, 5'h14, 32'h2);
    pulse(31'h2, 0); chk({nmi, vec, wa_l, wa_s, irq}, {1'b1, 5'h01, 8'h02, 8'h01, 1'b1});
    pulse(0, 31'h2); chk(req_l, 0);
    bus(1, 5'h10, 32'h3); chk(irq, 0);
    // vectors 0, 9 and 14 never raise in normal mode
    bus(1, 5'h04, 32'h7fff_ffff);
    bus(1, 5'h08, 32'h1);
    pulse(31'h4201, 0); chk(req_l, 0);
    pulse(31'h4002_0000, 0); chk({vec, wa_l, wa_s}, {5'h11, 8'h22, 8'h10});
    bus(1, 5'h00, 32'h2_0000); chk({vec, wa_l, wa_s}, {5'h1e, 8'h3c, 8'h19});
    bus(1, 5'h00, 32'h4000_0000); chk(req_l, 0);
    // random sources through enable, global enable and clear
    for (i = 0; i < 12; i = i + 1)
    begin
      v = 5'h1;
      while (v == 5'h1 || !((31'h7f32_3ffe >> v) & 1)) v = $unsigned($random(seed)) % 31;
      bus(1, 5'h08, 32'h2);
      bus(1, 5'h04, 32'h1 << v);
      pulse(31'h1 << v, 0); chk(req_l, 0);
      bus(1, 5'h10, 32'h3);
      bus(1, 5'h08, 32'h3);
      bus(0, 5'h0c, 0); chk(rd, {1'b1, 18'h0, v, wa(v, 1)});
      bus(0, 5'h10, 0); chk(rd, 32'h1);
      chk({req_s, wa_s}, {v != 5, v == 5 ? 8'h0 : wa(v, 0)});
      bus(1, 5'h04, 0); chk(req_l, 0);
      bus(1, 5'h04, 32'h1 << v); chk(req_l, 1);
      bus(1, 5'h00, 32'h1 << v); chk(req_l, 0);
    end
    end_sim;
  end
endmodule
